// File: logic/eed_consts.vh
`ifndef EED_CONSTS_VH
`define EED_CONSTS_VH

// Event point types
`define EED_TYPE_FETCH   2'h0
`define EED_TYPE_DATA    2'h1
`define EED_TYPE_IRQ     2'h2
`define EED_TYPE_TRIG    2'h3

// Qualifier bit positions within a point's 4-bit qualifier field
`define EED_Q_READ       0
`define EED_Q_WRITE      1
`define EED_Q_RANGE      2
`define EED_Q_DATA       3
`define EED_Q_IRQ_START  0
`define EED_Q_IRQ_END    1

// Combination modes
`define EED_MODE_OR      3'h0
`define EED_MODE_ACC     3'h1
`define EED_MODE_SIM     3'h2
`define EED_MODE_SUB     3'h3
`define EED_MODE_SEQ     3'h4
`define EED_MODE_STATE   3'h5

// Reset values
`define EED_RST_IDX      5'h00
`define EED_RST_MASK     16'h0000

`endif

// File: logic/eed_detector.v
`timescale 1ns/1ps
`include "eed_consts.vh"

module eed_detector
#(
   parameter NPT = 16,
   parameter AW  = 20,
   parameter DW  = 16,
   parameter TW  = 8
)
(
   // Clock and reset
   input  wire                clk,
   input  wire                reset,
   // Instruction bus of the target
   input  wire                ifetch_valid,
   input  wire                ifetch_exec,
   input  wire [AW-1:0]       ifetch_addr,
   // Data accesses of the target
   input  wire                dacc_valid,
   input  wire                dacc_write,
   input  wire [AW-1:0]       dacc_addr,
   input  wire [DW-1:0]       dacc_data,
   // Interrupt activity of the target
   input  wire                irq_enter,
   input  wire                irq_exit,
   // External trigger cable
   input  wire [TW-1:0]       trig_in,
   // Event point programming
   input  wire [NPT-1:0]      ev_en,
   input  wire [2*NPT-1:0]    ev_type,
   input  wire [4*NPT-1:0]    ev_qual,
   input  wire [AW*NPT-1:0]   ev_addr_lo,
   input  wire [AW*NPT-1:0]   ev_addr_hi,
   input  wire [DW*NPT-1:0]   ev_data,
   input  wire [DW*NPT-1:0]   ev_data_mask,
   // Combination programming
   input  wire [2:0]          comb_mode,
   input  wire [NPT-1:0]      comb_sel,
   input  wire [AW-1:0]       sub_lo,
   input  wire [AW-1:0]       sub_hi,
   input  wire [4*NPT-1:0]    seq_order,
   input  wire [4:0]          seq_len,
   input  wire [4*NPT-1:0]    st_go_mask,
   input  wire [7:0]          st_next,
   input  wire [1:0]          st_final,
   // Consumer routing
   input  wire                route_brk,
   input  wire                route_trc,
   input  wire                route_prf,
   // Results
   output reg                 hit_q,
   output reg                 brk_q,
   output reg                 trc_q,
   output reg                 prf_q,
   output reg  [NPT-1:0]      fire_q,
   output reg  [3:0]          st_q
);

   localparam [3:0] ST_S0 = 4'h1;
   localparam [3:0] ST_S1 = 4'h2;
   localparam [3:0] ST_S2 = 4'h4;
   localparam [3:0] ST_S3 = 4'h8;

   function in_range;
      input [AW-1:0] a;
      input [AW-1:0] lo;
      input [AW-1:0] hi;
      begin
         in_range = (a >= lo) && (a <= hi);
      end
   endfunction

   function [1:0] st_index;
      input [3:0] oh;
      begin
         case (oh)
            ST_S0:   st_index = 2'h0;
            ST_S1:   st_index = 2'h1;
            ST_S2:   st_index = 2'h2;
            ST_S3:   st_index = 2'h3;
            default: st_index = 2'h0;
         endcase
      end
   endfunction

   // An empty selection would otherwise count as all fired
   function all_fired;
      input [NPT-1:0] v;
      input [NPT-1:0] m;
      begin
         all_fired = (m != {NPT{1'b0}}) && ((v & m) == m);
      end
   endfunction

   function [3:0] st_code;
      input [1:0] idx;
      begin
         case (idx)
            2'h0:    st_code = ST_S0;
            2'h1:    st_code = ST_S1;
            2'h2:    st_code = ST_S2;
            default: st_code = ST_S3;
         endcase
      end
   endfunction

   reg  [NPT-1:0] fire;
   reg  [NPT-1:0] acc_q;
   reg  [4:0]     seq_idx_q;
   reg            in_sub_q;
   reg            hit_d;
   reg  [NPT-1:0] acc_d;
   reg  [4:0]     seq_idx_d;
   reg  [3:0]     st_d;
   reg            in_sub_d;
   reg  [3:0]     want;
   reg  [1:0]     cur;
   reg  [1:0]     nxt;
   reg  [AW-1:0]  lo;
   reg  [AW-1:0]  hi;
   reg  [3:0]     q;
   reg            ahit;
   integer        i;

   wire           exec_now = ifetch_valid & ifetch_exec;
   // Unprogrammed points carry a clear enable
   wire [NPT-1:0] sel = comb_sel & ev_en;
   // Only selected points feed any combination
   wire [NPT-1:0] fire_sel;
   assign fire_sel = fire & sel;
   // A match right after a hit is swallowed to keep pulses apart
   wire           pulse;
   assign pulse = hit_d & ~hit_q;

   // Per-point match, one comparator set each; all points run in parallel
   always @*
   begin
      fire = {NPT{1'b0}};
      lo   = {AW{1'b0}};
      hi   = {AW{1'b0}};
      q    = 4'h0;
      ahit = 1'b0;
      for (i = 0; i < NPT; i = i + 1)
      begin
         lo = ev_addr_lo[i*AW +: AW];
         hi = ev_addr_hi[i*AW +: AW];
         q  = ev_qual[i*4 +: 4];
         case (ev_type[i*2 +: 2])
            `EED_TYPE_FETCH:
               // Prefetch cycles carry ifetch_exec low and are ignored
               fire[i] = exec_now && (ifetch_addr == lo);
            `EED_TYPE_DATA:
            begin
               ahit = q[`EED_Q_RANGE] ? in_range(dacc_addr, lo, hi)
                                      : (dacc_addr == lo);
               fire[i] = dacc_valid && ahit
                  && (dacc_write ? q[`EED_Q_WRITE] : q[`EED_Q_READ])
                  && (!q[`EED_Q_DATA]
                      || (((dacc_data ^ ev_data[i*DW +: DW])
                           & ev_data_mask[i*DW +: DW]) == {DW{1'b0}}));
            end
            `EED_TYPE_IRQ:
               fire[i] = (irq_enter && q[`EED_Q_IRQ_START])
                      || (irq_exit && q[`EED_Q_IRQ_END]);
            `EED_TYPE_TRIG:
               fire[i] = (((trig_in ^ ev_data[i*DW +: TW])
                           & ev_data_mask[i*DW +: TW]) == {TW{1'b0}});
            default:
               fire[i] = 1'b0;
         endcase
      end
      fire = fire & ev_en;
   end

   // Combination of the selected points
   always @*
   begin
      hit_d     = 1'b0;
      acc_d     = acc_q;
      seq_idx_d = seq_idx_q;
      st_d      = st_q;
      in_sub_d  = in_sub_q;
      want      = seq_order[seq_idx_q[3:0]*4 +: 4];
      cur       = st_index(st_q);
      nxt       = st_next[cur*2 +: 2];
      // Range residency follows the last executed instruction
      if (exec_now)
      begin
         in_sub_d = in_range(ifetch_addr, sub_lo, sub_hi);
      end
      case (comb_mode)
         `EED_MODE_OR:
            hit_d = |fire_sel;
         `EED_MODE_ACC:
         begin
            acc_d = (acc_q | fire) & sel;
            hit_d = all_fired(acc_d, sel);
         end
         `EED_MODE_SIM:
            hit_d = all_fired(fire, sel);
         `EED_MODE_SUB:
            hit_d = in_sub_d && |fire_sel;
         `EED_MODE_SEQ:
         begin
            // A step naming a disabled point can never complete
            if ((seq_len != `EED_RST_IDX) && fire_sel[want])
            begin
               seq_idx_d = seq_idx_q + 5'h01;
               hit_d     = (seq_idx_d == seq_len);
            end
         end
         `EED_MODE_STATE:
         begin
            if (|(fire_sel & st_go_mask[cur*NPT +: NPT]))
            begin
               st_d  = st_code(nxt);
               hit_d = (nxt == st_final);
            end
         end
         default:
            hit_d = 1'b0;
      endcase
      // Restart from the initial state once the result fires
      if (hit_d)
      begin
         acc_d     = `EED_RST_MASK;
         seq_idx_d = `EED_RST_IDX;
         st_d      = ST_S0;
      end
   end

   // Result outputs straight from their registers
   always @(posedge clk)
   begin
      if (reset)
      begin
         hit_q  <= 1'b0;
         brk_q  <= 1'b0;
         trc_q  <= 1'b0;
         prf_q  <= 1'b0;
         fire_q <= `EED_RST_MASK;
      end
      else
      begin
         // Back-to-back matches still yield isolated one-cycle pulses
         hit_q  <= pulse;
         brk_q  <= pulse & route_brk;
         trc_q  <= pulse & route_trc;
         prf_q  <= pulse & route_prf;
         fire_q <= fire;
      end
   end

   // Combination progress
   always @(posedge clk)
   begin
      if (reset)
      begin
         acc_q     <= `EED_RST_MASK;
         seq_idx_q <= `EED_RST_IDX;
         st_q      <= ST_S0;
      end
      else
      begin
         acc_q     <= acc_d;
         seq_idx_q <= seq_idx_d;
         st_q      <= st_d;
      end
   end

   // Range residency survives hits and mode changes
   always @(posedge clk)
   begin
      if (reset)
      begin
         in_sub_q <= 1'b0;
      end
      else
      begin
         in_sub_q <= in_sub_d;
      end
   end

endmodule

// File: testbench/eed_detector_chk.sv
`timescale 1ns/1ps
module eed_detector_chk
#(
   parameter NPT = 16
)
(
   // Clock and reset
   input logic           clk,
   input logic           reset,
   // Programming
   input logic [NPT-1:0] ev_en,
   input logic [2:0]     comb_mode,
   input logic [NPT-1:0] comb_sel,
   input logic           route_brk,
   // Results
   input logic           hit_q,
   input logic           brk_q,
   input logic [NPT-1:0] fire_q,
   input logic [3:0]     st_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_PULSE:
      assert property (hit_q |=> !hit_q) else $error("hit too long");
   AST_BRK:
      assert property (brk_q == (hit_q && $past(route_brk)))
         else $error("break route");
   AST_OR:
      assert property ($past(comb_mode) == 3'h0 |-> hit_q ==
         (|(fire_q & $past(comb_sel)) && !$past(hit_q))) else $error("or");
   AST_SIM:
      assert property ($past(comb_mode) == 3'h2 && hit_q |->
         (fire_q & $past(comb_sel)) == $past(comb_sel)) else $error("sim");
   AST_ACC:
      assert property ($past(comb_mode) == 3'h1 && hit_q |->
         |(fire_q & $past(comb_sel))) else $error("accum");
   AST_DIS:
      assert property ((fire_q & ~$past(ev_en)) == '0) else $error("dis");
   AST_ONEHOT:
      assert property ($onehot(st_q)) else $error("state code");
   AST_STRET:
      assert property ($past(comb_mode) == 3'h5 && hit_q |-> st_q == 4'h1)
         else $error("state return");
endmodule

// File: testbench/eed_target.sv
`timescale 1ns/1ps
module eed_target
(
   // Clock and bench command
   input  logic        clk,
   input  logic [2:0]  cmd,
   input  logic [19:0] a,
   // Target buses
   output logic        ifetch_valid,
   output logic        ifetch_exec,
   output logic        dacc_valid,
   output logic        dacc_write,
   output logic [19:0] addr_q = 20'h00000,
   output logic [15:0] data_q = 16'h5A5A,
   output logic        irq_enter,
   output logic        irq_exit,
   output logic [7:0]  trig_in
);
   always @(posedge clk)
   begin
      ifetch_valid <= cmd == 3'h1 || cmd == 3'h2;
      ifetch_exec  <= cmd == 3'h1;
      dacc_valid   <= cmd == 3'h3 || cmd == 3'h4;
      dacc_write   <= cmd == 3'h4;
      // Idle bus inverts the last address each cycle
      addr_q       <= (cmd != 3'h0) ? a : ~addr_q;
      data_q       <= ~data_q;
      irq_enter    <= cmd == 3'h5;
      irq_exit     <= cmd == 3'h6;
      trig_in      <= {8{cmd == 3'h7}};
   end
endmodule

// File: testbench/eed_detector_tb.sv
`timescale 1ns/1ps
module eed_detector_tb;
   logic         clk = 0;
   logic         reset = 1;
   logic [2:0]   cmd = 0;
   logic [2:0]   mode = 0;
   logic [19:0]  a = 0;
   logic [15:0]  sel = 0;
   logic [319:0] lo;
   logic [319:0] hi;
   logic [255:0] dat = 256'hFF000000000000;
   wire          iv, ix, dv, dw, ie, ie2, hit, brk, trc, prf;
   logic         rb = 0;
   logic         rt = 0;
   logic         rp = 0;
   logic [15:0]  en = 16'h00BF;
   logic [31:0]  typ = 32'h09E4;
   logic [63:0]  qual = 64'h250120;
   logic [63:0]  ord = 64'h1;
   logic [4:0]   slen = 5'h02;
   wire  [19:0]  ta;
   wire  [15:0]  td, fire;
   wire  [7:0]   tg;
   wire  [3:0]   st;
   int           mismatches = 0;
   int           n_tests = 0;
   int           cyc = 0;
   always #2 clk = ~clk;
   eed_target eed_target_inst (.clk(clk), .cmd(cmd), .a(a),
      .ifetch_valid(iv), .ifetch_exec(ix), .dacc_valid(dv), .dacc_write(dw),
      .addr_q(ta), .data_q(td), .irq_enter(ie), .irq_exit(ie2), .trig_in(tg));
   eed_detector eed_detector_inst (.clk(clk), .reset(reset),
      .ifetch_valid(iv), .ifetch_exec(ix), .ifetch_addr(ta), .dacc_valid(dv),
      .dacc_write(dw), .dacc_addr(ta), .dacc_data(td), .irq_enter(ie),
      .irq_exit(ie2), .trig_in(tg), .ev_en(en), .ev_type(typ),
      .ev_qual(qual), .ev_addr_lo(lo), .ev_addr_hi(hi), .ev_data(dat),
      .ev_data_mask(dat), .comb_mode(mode), .comb_sel(sel),
      .sub_lo(20'h00100), .sub_hi(20'h001FF), .seq_order(ord),
      .seq_len(slen), .st_go_mask(64'h20001), .st_next(8'h09),
      .st_final(2'h2), .route_brk(rb), .route_trc(rt), .route_prf(rp),
      .hit_q(hit), .brk_q(brk), .trc_q(trc), .prf_q(prf), .fire_q(fire),
      .st_q(st));
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task ex(input logic [2:0] c, input logic [19:0] x, input logic e);
      @(posedge clk);
      cmd <= c;
      a <= x;
      @(posedge clk);
      cmd <= 3'h0;
      @(posedge clk);
      #1;
      chk("hit", {15'h0000, hit}, {15'h0000, e});
      chk("brk", {15'h0000, brk}, {15'h0000, e & rb});
      chk("trc", {15'h0000, trc}, {15'h0000, e & rt});
      chk("prf", {15'h0000, prf}, {15'h0000, e & rp});
   endtask
   // Reset between scenarios: mode changes keep old progress
   task cfg(input logic [2:0] m, input logic [15:0] s);
      @(posedge clk);
      reset <= 1'b1;
      mode <= m;
      sel <= s;
      rb <= s[2];
      rt <= s[0];
      rp <= s[1];
      @(posedge clk);
      reset <= 1'b0;
   endtask
   task t_or;
      logic [23:0] tv [8] = '{24'h900100, 24'h200100, 24'hC00200,
         24'h300200, 24'hB00305, 24'hD00000, 24'hE00000, 24'hF00000};
      cfg(3'h0, 16'h00BF);
      for (int i = 0; i < 8; i++)
         ex(tv[i][22:20], tv[i][19:0], tv[i][23]);
   endtask
   task t_acc;
      cfg(3'h1, 16'h0003);
      ex(3'h1, 20'h00100, 1'b0);
      ex(3'h4, 20'h00200, 1'b1);
      ex(3'h4, 20'h00200, 1'b0);
   endtask
   task t_sim;
      cfg(3'h2, 16'h0040);
      ex(3'h1, 20'h00100, 1'b0);
      cfg(3'h2, 16'h0003);
      ex(3'h1, 20'h00100, 1'b0);
      cfg(3'h2, 16'h0081);
      ex(3'h1, 20'h00100, 1'b1);
   endtask
   task t_seq;
      cfg(3'h4, 16'h0003);
      ex(3'h1, 20'h00100, 1'b0);
      ex(3'h4, 20'h00200, 1'b0);
      ex(3'h1, 20'h00100, 1'b1);
   endtask
   task t_sub;
      cfg(3'h3, 16'h0002);
      ex(3'h1, 20'h00500, 1'b0);
      ex(3'h4, 20'h00200, 1'b0);
      ex(3'h1, 20'h00180, 1'b0);
      ex(3'h4, 20'h00200, 1'b1);
   endtask
   task t_st;
      cfg(3'h5, 16'h0003);
      ex(3'h1, 20'h00100, 1'b0);
      chk("state", {12'h000, st}, 16'h0002);
      ex(3'h4, 20'h00200, 1'b1);
      chk("state", {12'h000, st}, 16'h0001);
   endtask
   task close_out;
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         mismatches++;
         close_out;
      end
   end
   initial
   begin
      lo = '0;
      lo[19:0] = 20'h00100;
      lo[39:20] = 20'h00200;
      lo[99:80] = 20'h00300;
      lo[139:120] = 20'h00100;
      lo[159:140] = 20'h00100;
      hi = lo;
      hi[99:80] = 20'h0030F;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_or;
      t_acc;
      t_sim;
      t_seq;
      t_sub;
      t_st;
      close_out;
   end
endmodule
bind eed_detector eed_detector_chk #(.NPT(NPT)) eed_detector_chk_inst
   (.clk(clk), .reset(reset), .ev_en(ev_en), .comb_mode(comb_mode),
   .comb_sel(comb_sel), .route_brk(route_brk), .hit_q(hit_q),
   .brk_q(brk_q), .fire_q(fire_q), .st_q(st_q));
